// [design/event_driven_pwm_core.sv]
// Event-driven 16-bit pulse generator with register port
// Operation
// - Event inputs from comparators, pin, capture units
// - Blanking forces selected comparator and pin inputs inactive
// - Period, rising and falling events drive pulse
// - Period event from any selected source combination
// - One rising, one falling accepted per period
// - Accepted rising event starts pulse immediately
// - Rising after falling in period is suppressed
// - Accepted falling event ends pulse immediately
// - Falling persisting into next period blocks rising
// - Clock from pin, 64 MHz or system
// - Clock selection independent of processor clock
// - 16-bit counter counts up every clock while enabled
// - Period match makes event, counter returns zero
// - Phase match makes rising edge event
// - Duty match makes falling edge event
// - Duty equal phase gives zero duty
// - Duty above period gives full duty
// - Set-reset latch combines accepted edge events
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module event_driven_pwm_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire pwm_core_pkg::bus_req_type bus_req,
  output logic [15:0] rdata_ff,
  input wire pwm_core_pkg::event_in_type event_in,
  output logic [1:0] clk_sel_ff,
  output logic pulse_out_ff,
  output logic period_event_ff
);
  localparam int sw = pwm_core_pkg::src_width;

  typedef enum logic [1:0] {
    idle_st = 2'b00,
    wait_rise_st = 2'b01,
    active_st = 2'b10,
    done_st = 2'b11
  } phase_type;

  logic [15:0] control_ff;
  logic [15:0] count_ff;
  logic [15:0] period_ff;
  logic [15:0] phase_ff;
  logic [15:0] duty_ff;
  logic [sw-1:0] period_src_ff;
  logic [sw-1:0] rise_src_ff;
  logic [sw-1:0] fall_src_ff;
  logic [pwm_core_pkg::blank_width-1:0] blank_sel_ff;
  logic [7:0] blank_len_ff;
  logic [7:0] blank_cnt_ff;
  logic pulse_was_ff;
  phase_type state_ff;
  phase_type nxt_state;

  // Select combination of sources; any selected input fires the event
  function automatic logic pick(input logic [sw-1:0] sel,
                                input logic [sw-1:0] srcs);
    pick = |(sel & srcs);
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b,
                               input logic strobe);
    hit = strobe && (a == b);
  endfunction

  wire enable = control_ff[pwm_core_pkg::ctl_enable_bit];
  wire [1:0] clk_sel = control_ff[pwm_core_pkg::ctl_clk_sel_lsb +: 2];
  wire blanking = (blank_cnt_ff != 8'h00);
  // Blank only comparator and pin inputs, capture outputs pass
  wire [pwm_core_pkg::blank_width-1:0] blankable =
    {event_in.cmp, event_in.pin};
  wire [pwm_core_pkg::blank_width-1:0] blanked =
    blanking ? (blankable & ~blank_sel_ff) : blankable;
  wire period_match = (count_ff == period_ff);
  wire phase_match = (count_ff == phase_ff);
  wire duty_match = (count_ff == duty_ff);
  // Shared input vector, counter match slot differs per event
  wire [sw-1:0] ext_srcs = {event_in.capture_compare_unit, blanked, 1'b0};
  wire [sw-1:0] per_srcs = ext_srcs | {{(sw-1){1'b0}}, period_match};
  wire [sw-1:0] rise_srcs = ext_srcs | {{(sw-1){1'b0}}, phase_match};
  wire [sw-1:0] fall_srcs = ext_srcs | {{(sw-1){1'b0}}, duty_match};
  wire period_evt = enable && pick(period_src_ff, per_srcs);
  wire rise_evt = enable && pick(rise_src_ff, rise_srcs);
  wire fall_evt = enable && pick(fall_src_ff, fall_srcs);
  wire count_wrap = period_evt || (period_match && enable);

  // Edge sequencer with the pulse latch held in the state
  always_comb begin
    nxt_state = state_ff;
    if (!enable) begin
      nxt_state = idle_st;
    end else if (period_evt) begin
      // Falling still asserted at period start blocks this period
      if (fall_evt) begin
        nxt_state = done_st;
      end else if (state_ff == active_st) begin
        // Latch holds across period with no falling match
        nxt_state = active_st;
      end else begin
        nxt_state = wait_rise_st;
      end
    end else begin
      case (state_ff)
        idle_st: begin
          nxt_state = wait_rise_st;
        end
        wait_rise_st: begin
          // Coincident falling wins so equal phase and duty is 0%
          if (fall_evt) begin
            nxt_state = done_st;
          end else if (rise_evt) begin
            nxt_state = active_st;
          end
        end
        active_st: begin
          if (fall_evt) begin
            nxt_state = done_st;
          end
        end
        done_st: begin
          // Further edges ignored until next period
          nxt_state = done_st;
        end
        default: begin
          nxt_state = idle_st;
        end
      endcase
    end
  end

  wire nxt_pulse = (nxt_state == active_st);

  // Counter runs every clock of the selected modulator clock
  wire [15:0] nxt_count = count_wrap ? pwm_core_pkg::count_reset :
                          (count_ff + 16'h0001);

  wire wr_ctl = hit(bus_req.addr, pwm_core_pkg::addr_control, bus_req.wr);
  wire wr_tb = hit(bus_req.addr, pwm_core_pkg::addr_time_base, bus_req.wr);
  wire wr_per = hit(bus_req.addr, pwm_core_pkg::addr_period, bus_req.wr);
  wire wr_ph = hit(bus_req.addr, pwm_core_pkg::addr_phase, bus_req.wr);
  wire wr_dc = hit(bus_req.addr, pwm_core_pkg::addr_duty, bus_req.wr);
  wire wr_ps = hit(bus_req.addr, pwm_core_pkg::addr_period_src, bus_req.wr);
  wire wr_rs = hit(bus_req.addr, pwm_core_pkg::addr_rise_src, bus_req.wr);
  wire wr_fs = hit(bus_req.addr, pwm_core_pkg::addr_fall_src, bus_req.wr);
  wire wr_bs = hit(bus_req.addr, pwm_core_pkg::addr_blank_sel, bus_req.wr);
  wire wr_bl = hit(bus_req.addr, pwm_core_pkg::addr_blank_len, bus_req.wr);

  logic [15:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 16'h0000;
    case (bus_req.addr)
      pwm_core_pkg::addr_control: nxt_rdata = control_ff;
      pwm_core_pkg::addr_time_base: nxt_rdata = count_ff;
      pwm_core_pkg::addr_period: nxt_rdata = period_ff;
      pwm_core_pkg::addr_phase: nxt_rdata = phase_ff;
      pwm_core_pkg::addr_duty: nxt_rdata = duty_ff;
      pwm_core_pkg::addr_period_src: nxt_rdata = {8'h00, period_src_ff};
      pwm_core_pkg::addr_rise_src: nxt_rdata = {8'h00, rise_src_ff};
      pwm_core_pkg::addr_fall_src: nxt_rdata = {8'h00, fall_src_ff};
      pwm_core_pkg::addr_blank_sel: nxt_rdata = {11'h000, blank_sel_ff};
      pwm_core_pkg::addr_blank_len: nxt_rdata = {8'h00, blank_len_ff};
      pwm_core_pkg::addr_status: nxt_rdata = {13'h0000, blanking,
                                              state_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Blanking window restarts on each output edge while enabled, where switching noise is
  wire out_edge = (nxt_pulse != pulse_was_ff) && enable;
  wire [7:0] nxt_blank_cnt = out_edge ? blank_len_ff :
                             (blanking ? (blank_cnt_ff - 8'h01) : 8'h00);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      control_ff <= pwm_core_pkg::control_reset;
      period_ff <= pwm_core_pkg::period_reset;
      phase_ff <= pwm_core_pkg::match_reset;
      duty_ff <= pwm_core_pkg::match_reset;
    end else begin
      if (wr_ctl) begin
        control_ff <= bus_req.wdata;
      end
      if (wr_per) begin
        period_ff <= bus_req.wdata;
      end
      if (wr_ph) begin
        phase_ff <= bus_req.wdata;
      end
      if (wr_dc) begin
        duty_ff <= bus_req.wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      period_src_ff <= pwm_core_pkg::src_reset;
      rise_src_ff <= pwm_core_pkg::src_reset;
      fall_src_ff <= pwm_core_pkg::src_reset;
      blank_sel_ff <= '0;
      blank_len_ff <= pwm_core_pkg::blank_len_reset;
    end else begin
      if (wr_ps) begin
        period_src_ff <= bus_req.wdata[sw-1:0];
      end
      if (wr_rs) begin
        rise_src_ff <= bus_req.wdata[sw-1:0];
      end
      if (wr_fs) begin
        fall_src_ff <= bus_req.wdata[sw-1:0];
      end
      if (wr_bs) begin
        blank_sel_ff <= bus_req.wdata[pwm_core_pkg::blank_width-1:0];
      end
      if (wr_bl) begin
        blank_len_ff <= bus_req.wdata[7:0];
      end
    end
  end

  // Software write to the counter takes priority over counting
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_ff <= pwm_core_pkg::count_reset;
    end else if (wr_tb) begin
      count_ff <= bus_req.wdata;
    end else if (enable) begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= idle_st;
      pulse_was_ff <= 1'b0;
      pulse_out_ff <= 1'b0;
      period_event_ff <= 1'b0;
      blank_cnt_ff <= 8'h00;
      clk_sel_ff <= pwm_core_pkg::clk_src_sys;
      rdata_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      pulse_was_ff <= nxt_pulse;
      // Output flop adds one cycle; no extra delay beyond it
      pulse_out_ff <= nxt_pulse;
      period_event_ff <= period_evt;
      blank_cnt_ff <= nxt_blank_cnt;
      clk_sel_ff <= clk_sel;
      rdata_ff <= bus_req.rd ? nxt_rdata : 16'h0000;
    end
  end
endmodule

// [design/pwm_core_pkg.sv]
// Package of register map, field layout and constants for the PWM core
package pwm_core_pkg;
  localparam logic [3:0] addr_control = 4'h0;
  localparam logic [3:0] addr_time_base = 4'h1;
  localparam logic [3:0] addr_period = 4'h2;
  localparam logic [3:0] addr_phase = 4'h3;
  localparam logic [3:0] addr_duty = 4'h4;
  localparam logic [3:0] addr_period_src = 4'h5;
  localparam logic [3:0] addr_rise_src = 4'h6;
  localparam logic [3:0] addr_fall_src = 4'h7;
  localparam logic [3:0] addr_blank_sel = 4'h8;
  localparam logic [3:0] addr_blank_len = 4'h9;
  localparam logic [3:0] addr_status = 4'ha;
  // Control fields
  localparam int ctl_enable_bit = 0;
  localparam int ctl_clk_sel_lsb = 1;
  localparam logic [15:0] control_reset = 16'h0000;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] period_reset = 16'hffff;
  localparam logic [15:0] match_reset = 16'h0000;
  localparam logic [7:0] src_reset = 8'h00;
  localparam logic [7:0] blank_len_reset = 8'h00;
  // Event source select bits: 0 counter match, 1 pin, 2..5 comparators,
  // 6..7 capture/compare units
  localparam int src_width = 8;
  localparam int src_match_bit = 0;
  localparam int src_pin_bit = 1;
  localparam int src_cmp_lsb = 2;
  localparam int src_ccp_lsb = 6;
  localparam int cmp_count = 4;
  localparam int ccp_count = 2;
  localparam int blank_width = 5;
  // Clock source encodings
  localparam logic [1:0] clk_src_sys = 2'h0;
  localparam logic [1:0] clk_src_int64 = 2'h1;
  localparam logic [1:0] clk_src_ext = 2'h2;
  localparam int internal_clk_mhz = 64;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [ccp_count-1:0] capture_compare_unit;
    logic [cmp_count-1:0] cmp;
    logic pin;
  } event_in_type;
endpackage

// [testbench/pwm_core_sva.sv]
// Port checker for the event driven PWM core
`timescale 1ns/10ps
module pwm_core_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire pwm_core_pkg::bus_req_type bus_req,
  input wire logic [15:0] rdata_ff,
  input wire pwm_core_pkg::event_in_type event_in,
  input wire logic [1:0] clk_sel_ff,
  input wire logic pulse_out_ff,
  input wire logic period_event_ff
);
  logic [15:0] sh_ff [0:10];
  logic ever_ff;
  logic seen_ff;
  logic zero_cfg;
  logic full_cfg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadow of writes; status writes fall in an unused slot
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 11; i++) begin
        sh_ff[i] <= 16'h0000;
      end
      sh_ff[2] <= pwm_core_pkg::period_reset;
    end else if (bus_req.wr && bus_req.addr < 4'hb) begin
      sh_ff[bus_req.addr] <= bus_req.wdata;
    end
  end
  always_ff @(posedge clk) begin
    ever_ff <= rst_b && (ever_ff || sh_ff[0][0]);
    seen_ff <= rst_b && !period_event_ff && (seen_ff || $fell(pulse_out_ff));
  end
  assign zero_cfg = sh_ff[3] == sh_ff[4] && sh_ff[6] == 16'h0001
    && sh_ff[7] == 16'h0001;
  assign full_cfg = sh_ff[0][0] && sh_ff[4] > sh_ff[2]
    && sh_ff[5] == 16'h0001 && sh_ff[7] == 16'h0001;
  property p_reset_quiet;
    disable iff (1'b0) !rst_b |=> !pulse_out_ff && !period_event_ff
      && rdata_ff == 16'h0000;
  endproperty
  property p_idle_until_en;
    !ever_ff |-> !pulse_out_ff && !period_event_ff;
  endproperty
  property p_clk_sel;
    bus_req.wr && bus_req.addr == pwm_core_pkg::addr_control |-> ##2
      clk_sel_ff == $past(bus_req.wdata[2:1], 2);
  endproperty
  // Only a period event may re-arm the rising edge
  property p_no_refire;
    seen_ff && !period_event_ff |-> !$rose(pulse_out_ff);
  endproperty
  property p_rd_period;
    bus_req.rd && bus_req.addr == pwm_core_pkg::addr_period |=>
      rdata_ff == $past(sh_ff[2]);
  endproperty
  sequence s_load_then_read;
    bus_req.wr && bus_req.addr == pwm_core_pkg::addr_time_base ##1
      bus_req.rd && bus_req.addr == pwm_core_pkg::addr_time_base;
  endsequence
  property p_count_load;
    s_load_then_read |=> rdata_ff == $past(bus_req.wdata, 2);
  endproperty
  property p_zero_duty;
    zero_cfg ##1 zero_cfg |-> !$rose(pulse_out_ff);
  endproperty
  property p_full_duty;
    full_cfg ##1 full_cfg |-> !$fell(pulse_out_ff);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active after reset");
  a_idle_until_en: assert property (p_idle_until_en)
    else $error("output active before enable");
  a_clk_sel: assert property (p_clk_sel)
    else $error("clock select differs from control write");
  a_no_refire: assert property (p_no_refire)
    else $error("second rising edge in one period");
  a_rd_period: assert property (p_rd_period)
    else $error("period read back wrong");
  a_count_load: assert property (p_count_load)
    else $error("time base load not read back");
  a_zero_duty: assert property (p_zero_duty)
    else $error("pulse at zero duty");
  a_full_duty: assert property (p_full_duty)
    else $error("pulse fell at full duty");
  c_pulse: cover property ($rose(pulse_out_ff));
  c_period: cover property (period_event_ff ##[1:20] period_event_ff);
  c_chatter: cover property (seen_ff && event_in.cmp[1]);
endmodule

// [testbench/switch_stage_model.sv]
// Power stage and comparator model facing the PWM core
`timescale 1ns/10ps
module switch_stage_model (
  input wire logic clk,
  input wire logic pulse,
  input wire logic [7:0] trip,
  input wire logic hold,
  output pwm_core_pkg::event_in_type ev
);
  logic [7:0] ramp_ff;
  logic [3:0] ring_ff;
  logic pulse_d_ff;
  // Current ramps while on; comparator 0 trips at the set level
  always_ff @(posedge clk) begin
    ramp_ff <= pulse ? ramp_ff + 8'h01 : 8'h00;
    pulse_d_ff <= pulse;
    ring_ff <= (pulse_d_ff && !pulse) ? 4'h5 : {1'b0, ring_ff[3:1]};
  end
  // Turn-off ringing chatters on comparator 1
  assign ev.cmp = {2'h0, ring_ff[0], pulse && ramp_ff >= trip};
  assign ev.pin = hold;
  assign ev.capture_compare_unit = {1'b0, hold};
endmodule

// [testbench/test_event_driven_pwm_core.sv]
// Self-checking bench of the PWM core
`timescale 1ns/10ps
module test_event_driven_pwm_core;
  typedef struct {
    logic [15:0] dc, rsrc, fsrc, blk;
    logic [7:0] trip;
    logic hold;
    int hi, rises;
  } row_type;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  pwm_core_pkg::bus_req_type bus_req = '0;
  pwm_core_pkg::event_in_type event_in;
  logic [15:0] rdata_ff;
  logic [1:0] clk_sel_ff;
  logic pulse_out_ff;
  logic period_event_ff;
  logic [7:0] trip = 8'h00;
  logic hold = 1'b0;
  int fails = 0;
  int tests_run = 0;
  int len, hi, rises;
  row_type rows [7] = '{
    '{16'h0006, 16'h0001, 16'h0001, 16'h0000, 8'h00, 1'b0, 4, 1},
    '{16'h0002, 16'h0001, 16'h0001, 16'h0000, 8'h00, 1'b0, 0, 0},
    '{16'h000c, 16'h0001, 16'h0001, 16'h0000, 8'h00, 1'b0, 10, 0},
    '{16'h000c, 16'h0001, 16'h0004, 16'h0000, 8'h02, 1'b0, 3, 1},
    '{16'h000c, 16'h0001, 16'h0040, 16'h0000, 8'h00, 1'b1, 0, 0},
    '{16'h0004, 16'h0009, 16'h0001, 16'h0000, 8'h00, 1'b0, 2, 1},
    '{16'h000c, 16'h0001, 16'h0004, 16'h0005, 8'h00, 1'b0, 6, 1}
  };
  event_driven_pwm_core i_event_driven_pwm_core (.clk(clk), .rst_b(rst_b),
    .bus_req(bus_req), .rdata_ff(rdata_ff), .event_in(event_in),
    .clk_sel_ff(clk_sel_ff), .pulse_out_ff(pulse_out_ff),
    .period_event_ff(period_event_ff));
  switch_stage_model i_switch_stage_model (.clk(clk), .pulse(pulse_out_ff),
    .trip(trip), .hold(hold), .ev(event_in));
  always #4 clk = ~clk;
  task automatic chk(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic [15:0] d,
    input logic w, input logic r);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(a, d, 1'b1, 1'b0);
    bus(a, 16'h0000, 1'b0, 1'b0);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    bus(a, 16'h0000, 1'b0, 1'b1);
    bus(a, 16'h0000, 1'b0, 1'b0);
    #1;
    chk("read data", rdata_ff, exp);
  endtask
  // One window spans period event to period event
  task automatic measure();
    logic prev;
    int n;
    n = 0;
    while (period_event_ff !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    len = 0;
    hi = 0;
    rises = 0;
    prev = pulse_out_ff;
    do begin
      @(posedge clk);
      #1;
      len++;
      hi += int'(pulse_out_ff === 1'b1);
      rises += int'(pulse_out_ff === 1'b1 && prev === 1'b0);
      prev = pulse_out_ff;
    end while (period_event_ff !== 1'b1 && len < 300);
  endtask
  task automatic summarize();
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wr(pwm_core_pkg::addr_period, 16'h0009);
    wr(pwm_core_pkg::addr_phase, 16'h0002);
    wr(pwm_core_pkg::addr_period_src, 16'h0001);
    wr(pwm_core_pkg::addr_blank_sel, 16'h0002);
    wr(pwm_core_pkg::addr_control, 16'h0001);
    foreach (rows[i]) begin
      wr(pwm_core_pkg::addr_duty, rows[i].dc);
      trip <= rows[i].trip;
      hold <= rows[i].hold;
      wr(pwm_core_pkg::addr_rise_src, rows[i].rsrc);
      wr(pwm_core_pkg::addr_fall_src, rows[i].fsrc);
      wr(pwm_core_pkg::addr_blank_len, rows[i].blk);
      measure();
      measure();
      chk("period", 16'(len), 16'h000a);
      if (rows[i].blk != 16'h0000)
        chk("blanked", 16'(hi >= 5 && hi <= 7), 16'h0001);
      else
        chk("high", 16'(hi), 16'(rows[i].hi));
      chk("rises", 16'(rises), 16'(rows[i].rises));
    end
    for (int s = 0; s < 3; s++) begin
      wr(pwm_core_pkg::addr_control, 16'(s * 2));
      @(posedge clk);
      #1;
      chk("clock select", 16'(clk_sel_ff), 16'(s));
    end
    bus(pwm_core_pkg::addr_time_base, 16'h1234, 1'b1, 1'b0);
    rd_chk(pwm_core_pkg::addr_time_base, 16'h1234);
    wr(4'hb, 16'hbeef);
    rd_chk(4'hb, 16'h0000);
    wr(pwm_core_pkg::addr_control, 16'h0001);
    repeat (20) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk("pulse", 16'(pulse_out_ff), 16'h0000);
    for (int a = 0; a < 10; a++) begin
      rd_chk(4'(a), a == 2 ? pwm_core_pkg::period_reset : 16'h0000);
    end
    summarize();
  end
endmodule
bind event_driven_pwm_core pwm_core_sva i_pwm_core_sva (.clk(clk),
  .rst_b(rst_b), .bus_req(bus_req), .rdata_ff(rdata_ff),
  .event_in(event_in), .clk_sel_ff(clk_sel_ff),
  .pulse_out_ff(pulse_out_ff), .period_event_ff(period_event_ff));
